// ---- logic/cpu_ctrl_defs.vh ----
`ifndef CPU_CTRL_DEFS_VH
`define CPU_CTRL_DEFS_VH

// program memory reserved regions
`define VEC_BASE        16'h0000
`define VEC_END         16'h003f
`define VEC_BRK         16'h003e
`define TABLE_CALL_INSTRUCTION_BASE      16'h0040
`define TABLE_CALL_INSTRUCTION_END       16'h007f
`define OPT_BASE        16'h0080
`define OPT_END         16'h0084
`define OPT_SWAP_BASE   16'h1080
`define OPT_SWAP_END    16'h1084
`define FAR_CALL_INSTRUCTION_BASE      16'h0800
`define FAR_CALL_INSTRUCTION_END       16'h0fff
`define COMMON_END      16'h7fff
`define BANK_BASE       16'h8000
`define BANK_END        16'hbfff
`define BANK_PHYS_BASE  17'h08000
`define NUM_BANKS       3'h6

// data memory regions
`define EXP_BASE        16'he000
`define EXP_END         16'hf7ff
`define HSRAM_BASE      16'hfb00
`define HSRAM_END       16'hfeff
`define GPR_BASE        16'hfee0
`define GPR_END         16'hfeff
`define SFR_BASE        16'hff00

// one flag bit per region; GPR addresses also set the HSRAM flag
`define REGION_W        9
`define RG_VEC          0
`define RG_TABLE_CALL_INSTRUCTION        1
`define RG_OPT          2
`define RG_FAR_CALL_INSTRUCTION        3
`define RG_BANK         4
`define RG_EXP          5
`define RG_HSRAM        6
`define RG_GPR          7
`define RG_SFR          8

// status word fields
`define PSW_IE          7
`define PSW_Z           6
`define PSW_REGISTER_BANK_SEL_HIGH        5
`define PSW_AC          4
`define PSW_REGISTER_BANK_SEL_LOW        3
`define PSW_RSVD        2
`define PSW_ISP         1
`define PSW_CY          0
`define PSW_RESET       8'h02

`define SP_RESET        16'h0000
`define SP_STEP         16'h0001
`define VEC_STEP        16'h0001

// alu flag operations
`define OP_ADD          2'h0
`define OP_SUB          2'h1
`define OP_ROT          2'h2
`define OP_BIT          2'h3

// apb register offsets
`define REG_PSW         8'h00
`define REG_PC          8'h04
`define REG_SP          8'h08
`define REG_BANK        8'h0c
`define REG_STAT        8'h10

`endif

// ---- logic/flag_calc.v ----
`timescale 1ns/100ps
`include "cpu_ctrl_defs.vh"

module flag_calc (
    // operation
    input  wire [1:0] i_op,
    input  wire [7:0] i_a,
    input  wire [7:0] i_b,
    input  wire       i_bit_val,
    // result and flags
    output reg  [7:0] o_result,
    output reg        o_zero,
    output reg        o_aux,
    output reg        o_carry
);

    wire [8:0] sum  = {1'b0, i_a} + {1'b0, i_b};
    wire [8:0] diff = {1'b0, i_a} - {1'b0, i_b};
    wire [4:0] lsum = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
    wire [4:0] ldif = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]};

    always @* begin
        o_result = i_a;
        o_aux    = 1'b0;
        o_carry  = 1'b0;
        case (i_op)
            `OP_ADD: begin
                o_result = sum[7:0];
                o_aux    = lsum[4];
                o_carry  = sum[8];
            end
            `OP_SUB: begin
                o_result = diff[7:0];
                o_aux    = ldif[4];
                o_carry  = diff[8];
            end
            `OP_ROT: begin
                // rotate left, bit 7 goes round and out to carry
                o_result = {i_a[6:0], i_a[7]};
                o_carry  = i_a[7];
            end
            default: begin
                o_carry  = i_bit_val;
            end
        endcase
        o_zero = (o_result == 8'h00);
    end

endmodule

// ---- logic/region_decode.v ----
`timescale 1ns/100ps
`include "cpu_ctrl_defs.vh"

module region_decode (
    // address in
    input  wire [15:0]            i_addr,
    input  wire [2:0]             i_bank,
    // classification
    output wire [`REGION_W-1:0]   o_region,
    output wire                   o_exec_ok,
    output wire                   o_stack_ok,
    output wire [16:0]            o_phys_addr
);

    wire in_vec   = (i_addr <= `VEC_END);
    wire in_table_call_instruction = (i_addr >= `TABLE_CALL_INSTRUCTION_BASE) && (i_addr <= `TABLE_CALL_INSTRUCTION_END);
    wire in_opt   = ((i_addr >= `OPT_BASE) && (i_addr <= `OPT_END)) ||
                    ((i_addr >= `OPT_SWAP_BASE) &&
                     (i_addr <= `OPT_SWAP_END));
    wire in_far_call_instruction = (i_addr >= `FAR_CALL_INSTRUCTION_BASE) && (i_addr <= `FAR_CALL_INSTRUCTION_END);
    wire in_bank  = (i_addr >= `BANK_BASE) && (i_addr <= `BANK_END);
    wire in_exp   = (i_addr >= `EXP_BASE) && (i_addr <= `EXP_END);
    wire in_hsram = (i_addr >= `HSRAM_BASE) && (i_addr <= `HSRAM_END);
    wire in_gpr   = (i_addr >= `GPR_BASE) && (i_addr <= `GPR_END);
    wire in_sfr   = (i_addr >= `SFR_BASE);
    wire in_rom   = (i_addr <= `BANK_END);

    assign o_region = {in_sfr, in_gpr, in_hsram, in_exp, in_bank,
                       in_far_call_instruction, in_opt, in_table_call_instruction, in_vec};

    // register banks and sfr space never hold code
    assign o_exec_ok  = (in_rom || in_exp || in_hsram) && !in_gpr;
    // only high-speed ram may hold the stack
    assign o_stack_ok = in_hsram;

    // window pages in one bank of 16 KB above the 32 KB common area
    assign o_phys_addr = in_bank ?
        (`BANK_PHYS_BASE + {i_bank, 14'h0000} + {3'h0, i_addr[13:0]}) :
        {1'b0, i_addr};

endmodule

// ---- logic/cpu_ctrl.v ----
`timescale 1ns/100ps
`include "cpu_ctrl_defs.vh"

module cpu_ctrl (
    // clock and reset
    input  wire                 i_clock,
    input  wire                 i_rst,
    // apb slave
    input  wire                 i_psel,
    input  wire                 i_penable,
    input  wire                 i_pwrite,
    input  wire [7:0]           i_paddr,
    input  wire [31:0]          i_pwdata,
    output reg  [31:0]          o_prdata,
    output wire                 o_pready,
    output wire                 o_pslverr,
    // vector and table read port
    output wire                 o_mem_req,
    output reg  [15:0]          o_mem_addr,
    input  wire                 i_mem_ack,
    input  wire [7:0]           i_mem_rdata,
    // reset causes: pin, power-on clear, low voltage, watchdog
    input  wire [3:0]           i_reset_cause,
    // program flow
    input  wire                 i_step,
    input  wire [2:0]           i_instr_len,
    input  wire                 i_branch,
    input  wire [15:0]          i_branch_target,
    input  wire                 i_table_call,
    input  wire [4:0]           i_table_index,
    input  wire                 i_far_call,
    input  wire [10:0]          i_far_offset,
    // interrupts
    input  wire                 i_irq_req,
    input  wire                 i_irq_low_pri,
    input  wire [4:0]           i_irq_slot,
    input  wire                 i_software_break,
    output wire                 o_irq_take,
    // status word control
    input  wire                 i_psw_push,
    input  wire                 i_psw_pop,
    input  wire                 i_int_return,
    input  wire [7:0]           i_stack_rdata,
    input  wire                 i_enable_ints,
    input  wire                 i_disable_ints,
    input  wire                 i_select_bank,
    input  wire [1:0]           i_bank_num,
    // alu flag update
    input  wire                 i_alu_valid,
    input  wire [1:0]           i_alu_op,
    input  wire [7:0]           i_alu_a,
    input  wire [7:0]           i_alu_b,
    input  wire                 i_bit_val,
    // data access checked against the map
    input  wire [15:0]          i_data_addr,
    // core state
    output reg  [15:0]          o_pc,
    output reg  [15:0]          o_sp,
    output reg  [7:0]           o_psw,
    output reg  [7:0]           o_alu_result,
    output wire                 o_busy,
    output wire [1:0]           o_gpr_bank,
    // stack write port
    output reg                  o_stack_we,
    output reg  [15:0]          o_stack_addr,
    output reg  [7:0]           o_stack_wdata,
    // map decode
    output wire [16:0]          o_fetch_phys,
    output wire                 o_fetch_exec_ok,
    output wire [`REGION_W-1:0] o_data_region,
    output wire [16:0]          o_data_phys,
    output wire                 o_stack_fault
);

    localparam ST_IDLE = 3'b001;
    localparam ST_LO   = 3'b010;
    localparam ST_HI   = 3'b100;

    reg  [2:0]            state_r;
    reg  [2:0]            state_nxt;
    reg  [15:0]           addr_nxt;
    reg  [7:0]            lo_r;
    reg  [7:0]            lo_nxt;
    reg  [15:0]           pc_nxt;
    reg  [15:0]           sp_nxt;
    reg  [7:0]            psw_nxt;
    reg                   push_nxt;
    reg  [15:0]           push_addr_nxt;
    reg  [7:0]            push_data_nxt;
    reg  [7:0]            alu_nxt;
    reg  [2:0]            bank_r;
    reg  [31:0]           rd_mux;

    wire [7:0]            alu_res;
    wire                  alu_z;
    wire                  alu_ac;
    wire                  alu_cy;
    wire [`REGION_W-1:0]  fetch_region;
    wire                  stack_ok;
    wire [15:0]           sp_dec = o_sp - `SP_STEP;

    wire idle      = state_r == ST_IDLE;
    wire any_reset = |i_reset_cause;

    // apb access phase; zero wait states
    wire apb_acc   = i_psel && i_penable;
    wire apb_wr    = apb_acc && i_pwrite;
    wire map_hit   = (i_paddr == `REG_PSW) || (i_paddr == `REG_PC) ||
                     (i_paddr == `REG_SP) || (i_paddr == `REG_BANK) ||
                     (i_paddr == `REG_STAT);
    wire ro_hit    = (i_paddr == `REG_PC) || (i_paddr == `REG_STAT);
    wire bank_bad  = (i_paddr == `REG_BANK) &&
                     (i_pwdata[2:0] >= `NUM_BANKS);

    assign o_pready  = 1'b1;
    assign o_pslverr = apb_acc &&
                       (!map_hit || (i_pwrite && (ro_hit || bank_bad)));

    // only vectored sources gated by the enable and priority flags
    assign o_irq_take = idle && !any_reset && i_irq_req &&
                        o_psw[`PSW_IE] &&
                        (o_psw[`PSW_ISP] || !i_irq_low_pri);

    assign o_mem_req  = !idle;
    assign o_busy     = !idle;
    assign o_gpr_bank = {o_psw[`PSW_REGISTER_BANK_SEL_HIGH], o_psw[`PSW_REGISTER_BANK_SEL_LOW]};
    assign o_stack_fault = !stack_ok;

    flag_calc u_flags (
        .i_op      (i_alu_op),
        .i_a       (i_alu_a),
        .i_b       (i_alu_b),
        .i_bit_val (i_bit_val),
        .o_result  (alu_res),
        .o_zero    (alu_z),
        .o_aux     (alu_ac),
        .o_carry   (alu_cy)
    );

    region_decode u_fetch_map (
        .i_addr      (o_pc),
        .i_bank      (bank_r),
        .o_region    (fetch_region),
        .o_exec_ok   (o_fetch_exec_ok),
        .o_stack_ok  (),
        .o_phys_addr (o_fetch_phys)
    );

    region_decode u_data_map (
        .i_addr      (i_data_addr),
        .i_bank      (bank_r),
        .o_region    (o_data_region),
        .o_exec_ok   (),
        .o_stack_ok  (),
        .o_phys_addr (o_data_phys)
    );

    // the next push lands at sp-1, so that is the address to check
    region_decode u_stack_map (
        .i_addr      (sp_dec),
        .i_bank      (bank_r),
        .o_region    (),
        .o_exec_ok   (),
        .o_stack_ok  (stack_ok),
        .o_phys_addr ()
    );

    always @* begin
        case (i_paddr)
            `REG_PSW:  rd_mux = {24'h000000, o_psw};
            `REG_PC:   rd_mux = {16'h0000, o_pc};
            `REG_SP:   rd_mux = {16'h0000, o_sp};
            `REG_BANK: rd_mux = {29'h00000000, bank_r};
            `REG_STAT: rd_mux = {20'h00000, o_busy, stack_ok,
                                 o_fetch_exec_ok, fetch_region};
            default:   rd_mux = 32'h00000000;
        endcase
    end

    always @* begin
        state_nxt     = state_r;
        addr_nxt      = o_mem_addr;
        lo_nxt        = lo_r;
        pc_nxt        = o_pc;
        sp_nxt        = o_sp;
        psw_nxt       = o_psw;
        push_nxt      = 1'b0;
        push_addr_nxt = o_stack_addr;
        push_data_nxt = o_stack_wdata;
        alu_nxt       = o_alu_result;
        // software writes first so that core events in the same cycle win
        if (apb_wr && (i_paddr == `REG_PSW)) begin
            psw_nxt = i_pwdata[7:0];
            psw_nxt[`PSW_RSVD] = 1'b0;
        end
        if (apb_wr && (i_paddr == `REG_SP)) begin
            sp_nxt = i_pwdata[15:0];
        end
        if (any_reset) begin
            state_nxt = ST_LO;
            addr_nxt  = `VEC_BASE;
            psw_nxt   = `PSW_RESET;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (o_irq_take || i_software_break) begin
                        push_nxt      = 1'b1;
                        push_addr_nxt = sp_dec;
                        push_data_nxt = o_psw;
                        sp_nxt        = sp_dec;
                        psw_nxt[`PSW_IE] = 1'b0;
                        // slot index doubles into the word address
                        addr_nxt  = o_irq_take ?
                            {10'h000, i_irq_slot, 1'b0} : `VEC_BRK;
                        state_nxt = ST_LO;
                    end else begin
                        if (i_table_call) begin
                            addr_nxt  = `TABLE_CALL_INSTRUCTION_BASE +
                                        {10'h000, i_table_index, 1'b0};
                            state_nxt = ST_LO;
                        end else if (i_far_call) begin
                            pc_nxt = `FAR_CALL_INSTRUCTION_BASE |
                                     {5'h00, i_far_offset};
                        end else if (i_branch) begin
                            pc_nxt = i_branch_target;
                        end else if (i_step) begin
                            pc_nxt = o_pc + {13'h0000, i_instr_len};
                        end
                        if (i_psw_push) begin
                            push_nxt      = 1'b1;
                            push_addr_nxt = sp_dec;
                            push_data_nxt = o_psw;
                            sp_nxt        = sp_dec;
                        end else if (i_psw_pop || i_int_return) begin
                            psw_nxt = i_stack_rdata;
                            psw_nxt[`PSW_RSVD] = 1'b0;
                            sp_nxt  = o_sp + `SP_STEP;
                        end
                        if (i_enable_ints) begin
                            psw_nxt[`PSW_IE] = 1'b1;
                        end else if (i_disable_ints) begin
                            psw_nxt[`PSW_IE] = 1'b0;
                        end
                        if (i_select_bank) begin
                            psw_nxt[`PSW_REGISTER_BANK_SEL_HIGH] = i_bank_num[1];
                            psw_nxt[`PSW_REGISTER_BANK_SEL_LOW] = i_bank_num[0];
                        end
                        if (i_alu_valid) begin
                            alu_nxt = alu_res;
                            psw_nxt[`PSW_CY] = alu_cy;
                            // rotate and bit ops touch carry only
                            if (!i_alu_op[1]) begin
                                psw_nxt[`PSW_Z]  = alu_z;
                                psw_nxt[`PSW_AC] = alu_ac;
                            end
                        end
                    end
                end
                ST_LO: begin
                    if (i_mem_ack) begin
                        lo_nxt    = i_mem_rdata;
                        addr_nxt  = o_mem_addr + `VEC_STEP;
                        state_nxt = ST_HI;
                    end
                end
                ST_HI: begin
                    if (i_mem_ack) begin
                        pc_nxt    = {i_mem_rdata, lo_r};
                        state_nxt = ST_IDLE;
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            // first word after reset comes from the reset vector
            state_r       <= ST_LO;
            o_mem_addr    <= `VEC_BASE;
            lo_r          <= 8'h00;
            o_pc          <= 16'h0000;
            o_sp          <= `SP_RESET;
            o_psw         <= `PSW_RESET;
            o_alu_result  <= 8'h00;
            o_stack_we    <= 1'b0;
            o_stack_addr  <= 16'h0000;
            o_stack_wdata <= 8'h00;
            bank_r        <= 3'h0;
            o_prdata      <= 32'h00000000;
        end else begin
            state_r       <= state_nxt;
            o_mem_addr    <= addr_nxt;
            lo_r          <= lo_nxt;
            o_pc          <= pc_nxt;
            o_sp          <= sp_nxt;
            o_psw         <= psw_nxt;
            o_alu_result  <= alu_nxt;
            o_stack_we    <= push_nxt;
            o_stack_addr  <= push_addr_nxt;
            o_stack_wdata <= push_data_nxt;
            // out-of-range bank numbers are refused, not wrapped
            if (apb_wr && (i_paddr == `REG_BANK) && !bank_bad) begin
                bank_r <= i_pwdata[2:0];
            end
            // read data is latched in the setup cycle so it comes from a flop
            if (i_psel && !i_penable) begin
                o_prdata <= rd_mux;
            end
        end
    end

endmodule

// ---- dv/cpu_ctrl_checker.sv ----
`timescale 1ns/100ps
module cpu_ctrl_checker (
    // clock and reset
    input wire        i_clock,
    input wire        i_rst,
    // sequencer events
    input wire [3:0]  i_reset_cause,
    input wire        i_step,
    input wire [2:0]  i_instr_len,
    input wire        i_branch,
    input wire        i_table_call,
    input wire        i_far_call,
    input wire [10:0] i_far_offset,
    input wire        i_irq_low_pri,
    input wire [4:0]  i_irq_slot,
    input wire        i_software_break,
    input wire        i_enable_ints,
    input wire        i_alu_valid,
    input wire [1:0]  i_alu_op,
    input wire        i_mem_ack,
    // observed state
    input wire        o_irq_take,
    input wire        o_busy,
    input wire        o_mem_req,
    input wire [15:0] o_mem_addr,
    input wire [15:0] o_pc,
    input wire [15:0] o_sp,
    input wire [7:0]  o_psw,
    input wire [7:0]  o_alu_result,
    input wire        o_stack_we,
    input wire [15:0] o_stack_addr,
    input wire [7:0]  o_stack_wdata,
    input wire        o_fetch_exec_ok
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // no higher-ranked event competes in this cycle
    wire calm = !o_busy && !o_irq_take && !i_software_break && !(|i_reset_cause);

    a_step_adv: assert property (calm && i_step && !i_branch && !i_table_call && !i_far_call |=> o_pc == $past(o_pc) + $past(i_instr_len)) else $error("pc step wrong");
    a_far_target: assert property (calm && i_far_call && !i_table_call |=> o_pc == {5'h01, $past(i_far_offset)}) else $error("far call target wrong");
    a_irq_gate: assert property (o_irq_take && !i_software_break |-> o_psw[7] && (o_psw[1] || !i_irq_low_pri)) else $error("interrupt taken while gated");
    a_irq_push: assert property (o_irq_take |=> o_stack_we && o_stack_addr == $past(o_sp) - 16'h0001 && o_stack_wdata == $past(o_psw) && !o_psw[7]) else $error("status push wrong");
    a_irq_vector: assert property (o_irq_take && !i_software_break |=> o_mem_req && o_mem_addr == {10'h000, $past(i_irq_slot), 1'b0}) else $error("vector slot wrong");
    a_vec_pair: assert property (o_mem_req && i_mem_ack && !o_mem_addr[0] && !(|i_reset_cause) |=> o_mem_addr == $past(o_mem_addr) + 16'h0001) else $error("vector high byte address wrong");
    a_alu_zero: assert property (i_alu_valid && !i_alu_op[1] && !(|i_reset_cause) |=> o_psw[6] == (o_alu_result == 8'h00)) else $error("zero flag wrong");
    a_ei_sets: assert property (calm && i_enable_ints |=> o_psw[7]) else $error("enable flag not set");
    a_gpr_noexec: assert property (o_pc >= 16'hfee0 && o_pc <= 16'hfeff |-> !o_fetch_exec_ok) else $error("register area executable");

    c_irq: cover property (o_irq_take);
    c_push: cover property (o_stack_we && !$past(o_irq_take));
    c_far: cover property (calm && i_far_call);
endmodule

bind cpu_ctrl cpu_ctrl_checker u_chk (.*);

// ---- dv/tb.sv ----
`timescale 1ns/100ps
`include "cpu_ctrl_defs.vh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb;
    reg         i_clock, i_rst, i_psel, i_penable, i_pwrite, i_mem_ack;
    reg         i_step, i_branch, i_table_call, i_far_call, i_irq_req;
    reg         i_irq_low_pri, i_software_break, i_psw_push, i_psw_pop;
    reg         i_int_return, i_enable_ints, i_disable_ints, i_select_bank;
    reg         i_alu_valid, i_bit_val, se;
    reg  [1:0]  i_bank_num, i_alu_op;
    reg  [2:0]  i_instr_len;
    reg  [3:0]  i_reset_cause;
    reg  [4:0]  i_table_index, i_irq_slot;
    reg  [7:0]  i_paddr, i_mem_rdata, i_stack_rdata, i_alu_a, i_alu_b, p;
    reg  [10:0] i_far_offset;
    reg  [15:0] i_branch_target, i_data_addr, s;
    reg  [31:0] i_pwdata, rd;
    wire [31:0] o_prdata;
    wire        o_pready, o_pslverr, o_mem_req, o_irq_take, o_busy;
    wire        o_stack_we, o_fetch_exec_ok, o_stack_fault;
    wire [15:0] o_mem_addr, o_pc, o_sp, o_stack_addr;
    wire [7:0]  o_psw, o_alu_result, o_stack_wdata;
    wire [1:0]  o_gpr_bank;
    wire [16:0] o_fetch_phys, o_data_phys;
    wire [`REGION_W-1:0] o_data_region;
    int         err_total, checks, i;
    logic [15:0] ma [14] = '{16'h0000, 16'h003f, 16'h0040, 16'h007f, 16'h0084,
        16'h1080, 16'h0085, 16'h0fff, 16'h1000, 16'hbfff, 16'hc000, 16'he000,
        16'hfb00, 16'hfee0};
    // region bit expected set; 16 added means expected clear
    int         mb [14] = '{0, 0, 1, 1, 2, 2, 18, 3, 19, 4, 20, 5, 6, 7};

    cpu_ctrl u_dut (.*);

    function automatic [7:0] rom(input [15:0] a);
        rom = a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    function automatic [15:0] vec(input [15:0] a);
        vec = {rom(a + 16'h0001), rom(a)};
    endfunction

    // slow memory: acks every other cycle so the address must hold
    always @(posedge i_clock) begin
        i_mem_ack <= o_mem_req & ~i_mem_ack;
        i_mem_rdata <= rom(o_mem_addr);
    end

    task clr;
        {i_step, i_branch, i_table_call, i_far_call, i_software_break,
         i_psw_push, i_psw_pop, i_int_return, i_enable_ints, i_disable_ints,
         i_select_bank, i_alu_valid, i_reset_cause} <= '0;
    endtask
    task go;
        @(posedge i_clock) clr;
        @(negedge i_clock);
        while (o_busy !== 1'b0) @(negedge i_clock);
    endtask
    task apb(input bit wr, input [7:0] a, input [31:0] wd);
        @(posedge i_clock);
        i_psel <= 1;
        i_penable <= 0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= wd;
        @(posedge i_clock);
        i_penable <= 1;
        @(posedge i_clock);
        while (o_pready !== 1'b1) @(posedge i_clock);
        rd = o_prdata;
        se = o_pslverr;
        i_psel <= 0;
        i_penable <= 0;
    endtask
    task brn(input [15:0] t);
        @(posedge i_clock);
        i_branch <= 1;
        i_branch_target <= t;
        go;
    endtask
    task alu(input [1:0] op, input [7:0] a, b, input bv, input [7:0] r,
             input [2:0] f);
        @(posedge i_clock);
        {i_alu_valid, i_alu_op, i_alu_a, i_alu_b, i_bit_val} <= {1'b1, op, a, b, bv};
        go;
        if (op != 2'h3) `CHK("alu_res", r, o_alu_result)
        if (op[1]) `CHK("cy", f[0], o_psw[0])
        else `CHK("z_ac_cy", f, ({o_psw[6], o_psw[4], o_psw[0]}))
    endtask

    task t_boot;
        go;
        `CHK("pc_boot", vec(16'h0000), o_pc)
        `CHK("psw_boot", 8'h02, o_psw)
        apb(0, 8'h00, 0);
        `CHK("psw_rd", 32'h02, rd)
        for (i = 0; i < 4; i++) begin
            @(posedge i_clock);
            i_enable_ints <= 1;
            brn(16'h2468);
            @(posedge i_clock);
            i_reset_cause[i] <= 1'b1;
            go;
            `CHK("pc_cause", vec(16'h0000), o_pc)
            `CHK("psw_cause", 8'h02, o_psw)
        end
    endtask
    task t_flow;
        @(posedge i_clock);
        i_step <= 1;
        i_instr_len <= 3'h7;
        go;
        `CHK("pc_step", vec(16'h0000) + 16'h0007, o_pc)
        @(posedge i_clock);
        i_table_call <= 1;
        i_table_index <= 5'h1f;
        go;
        `CHK("pc_table", vec(16'h007e), o_pc)
        @(posedge i_clock);
        i_far_call <= 1;
        i_far_offset <= 11'h7ff;
        go;
        `CHK("pc_far", 16'h0fff, o_pc)
        @(posedge i_clock);
        i_select_bank <= 1;
        i_bank_num <= 2'h2;
        go;
        `CHK("gpr_bank", 2'h2, o_gpr_bank)
        `CHK("psw_rbs", 2'h2, ({o_psw[5], o_psw[3]}))
        brn(16'hfee0);
        `CHK("exec_gpr", 1'b0, o_fetch_exec_ok)
        brn(16'he000);
        `CHK("exec_exp", 1'b1, o_fetch_exec_ok)
    endtask
    task t_irq;
        apb(1, 8'h08, 32'hfc00);
        @(posedge i_clock);
        i_enable_ints <= 1;
        go;
        p = o_psw;
        @(posedge i_clock);
        {i_irq_req, i_irq_low_pri, i_irq_slot} <= {2'b10, 5'h09};
        @(negedge i_clock);
        `CHK("take", 1'b1, o_irq_take)
        @(posedge i_clock);
        i_irq_req <= 0;
        @(negedge i_clock);
        `CHK("push", ({1'b1, 16'hfbff, p}), ({o_stack_we, o_stack_addr, o_stack_wdata}))
        `CHK("ie_ack", 1'b0, o_psw[7])
        go;
        `CHK("pc_irq", vec(16'h0012), o_pc)
        apb(1, 8'h00, 32'h80);
        {i_irq_req, i_irq_low_pri} <= 2'b11;
        @(negedge i_clock);
        `CHK("take_isp", 1'b0, o_irq_take)
        @(posedge i_clock);
        i_irq_low_pri <= 0;
        @(negedge i_clock);
        `CHK("take_high", 1'b1, o_irq_take)
        @(posedge i_clock);
        go;
        `CHK("take_ie0", 1'b0, o_irq_take)
        @(posedge i_clock);
        i_irq_req <= 0;
        i_software_break <= 1;
        go;
        `CHK("pc_brk", vec(16'h003e), o_pc)
        s = o_sp;
        @(posedge i_clock);
        {i_psw_pop, i_stack_rdata} <= {1'b1, 8'hc1};
        go;
        `CHK("pop", ({s + 16'h0001, 8'hc1}), ({o_sp, o_psw}))
        @(posedge i_clock);
        {i_int_return, i_stack_rdata} <= {1'b1, 8'h19};
        go;
        `CHK("interrupt_return_instruction", 8'h19, o_psw)
        @(posedge i_clock);
        i_psw_push <= 1;
        go;
        `CHK("pshw", ({1'b1, s + 16'h0001, 8'h19}), ({o_stack_we, o_stack_addr, o_stack_wdata}))
        @(posedge i_clock);
        i_enable_ints <= 1;
        go;
        @(posedge i_clock);
        i_disable_ints <= 1;
        go;
        `CHK("ie_di", 1'b0, o_psw[7])
    endtask
    task t_map;
        for (i = 0; i < 14; i++) begin
            @(posedge i_clock);
            i_data_addr <= ma[i];
            @(negedge i_clock);
            `CHK("region", mb[i] < 16, o_data_region[mb[i] % 16])
        end
        apb(1, 8'h0c, 5);
        i_data_addr <= 16'h9234;
        apb(1, 8'h0c, 6);
        `CHK("bank_err", 1'b1, se)
        apb(0, 8'h0c, 0);
        `CHK("bank_rd", ({1'b0, 32'h5, 17'h1d234}), ({se, rd, o_data_phys}))
        brn(16'h8000);
        `CHK("fetch_phys", 17'h1c000, o_fetch_phys)
        apb(0, 8'h14, 0);
        `CHK("unmapped", 1'b1, se)
        apb(1, 8'h08, 32'hfb01);
        @(negedge i_clock);
        `CHK("sfault_in", 1'b0, o_stack_fault)
        apb(1, 8'h08, 32'hfb00);
        @(negedge i_clock);
        `CHK("sfault_out", 1'b1, o_stack_fault)
    endtask

    task tally_and_finish;
        if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        i_clock = 0;
        forever #25 i_clock = ~i_clock;
    end
    initial begin
        repeat (8000) @(posedge i_clock);
        err_total++;
        tally_and_finish;
    end
    initial begin
        i_rst = 1;
        clr;
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_mem_ack, i_mem_rdata,
         i_irq_req, i_irq_low_pri, i_irq_slot, i_instr_len, i_branch_target,
         i_table_index, i_far_offset, i_stack_rdata, i_bank_num, i_alu_op,
         i_alu_a, i_alu_b, i_bit_val, i_data_addr} <= '0;
        repeat (12) @(posedge i_clock);
        i_rst <= 0;
        t_boot;
        t_flow;
        alu(2'h0, 8'h08, 8'h08, 0, 8'h10, 3'b010);
        alu(2'h0, 8'hff, 8'h01, 0, 8'h00, 3'b111);
        alu(2'h1, 8'h10, 8'h01, 0, 8'h0f, 3'b010);
        alu(2'h1, 8'h05, 8'h05, 0, 8'h00, 3'b100);
        alu(2'h1, 8'h00, 8'h01, 0, 8'hff, 3'b011);
        alu(2'h2, 8'h80, 8'h00, 0, 8'h01, 3'b001);
        alu(2'h2, 8'h40, 8'h00, 0, 8'h80, 3'b000);
        alu(2'h3, 8'h00, 8'h00, 1, 8'h00, 3'b001);
        alu(2'h3, 8'h00, 8'h00, 0, 8'h00, 3'b000);
        t_irq;
        t_map;
        tally_and_finish;
    end
endmodule
